/* pdm_mic.sv */
// Microphone end: strap decode, mode detect, idle pattern and modulator
`timescale 1ns/1ps
module pdm_mic #(
	parameter int SETTLE_CYC = pdm_pkg::SETTLE_HALF_CYC
) (
	// System
	input  wire logic                        mclk,
	input  wire logic                        rst,
	// Link
	pdm_link_if.mic                          link,
	// User side
	input  wire logic                        side_strap_state,
	input  wire logic signed [pdm_pkg::SAMPLE_W-1:0] pressure,
	output logic [2:0]                       power_mode,
	output logic                             audio_ready
);

	// Counter widths below are fixed, so refuse settings they cannot hold
	initial begin
		if (SETTLE_CYC < 1)
			$error("SETTLE_CYC must be positive");
		if (pdm_pkg::MEAS_WIN_CYC < 2 || pdm_pkg::MEAS_WIN_CYC > 1024)
			$error("MEAS_WIN_CYC does not fit the window counter");
		if (pdm_pkg::CLK_OFF_CYC < 1 || pdm_pkg::CLK_OFF_CYC > 255)
			$error("CLK_OFF_CYC does not fit the low-time counter");
		if (pdm_pkg::EDGE_W != 8)
			$error("EDGE_W must match the mode thresholds");
		if (pdm_pkg::OFS_PER_LOW < 1 || pdm_pkg::OFS_PER_LOW > 65535)
			$error("OFS_PER_LOW does not fit the offset counter");
		if (pdm_pkg::OFS_PER_HIGH < 1 || pdm_pkg::OFS_PER_HIGH > 65535)
			$error("OFS_PER_HIGH does not fit the offset counter");
		if (pdm_pkg::SAMPLE_W != 16)
			$error("SAMPLE_W must be 16 for the feedback step");
	end

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for the pin clock and strap
	logic clk_s1_r, clk_s2_r, clk_d_r, strap_s1_r, strap_s2_r;
	always_ff @(posedge mclk) begin
		clk_s1_r   <= link.pdm_clk;
		clk_s2_r   <= clk_s1_r;
		clk_d_r    <= clk_s2_r;
		strap_s1_r <= side_strap_state;
		strap_s2_r <= strap_s1_r;
	end
	wire rise_w = clk_s2_r & ~clk_d_r;
	wire fall_w = ~clk_s2_r & clk_d_r;

	////////////////////////////////////////////////////////////////////////
	// Strap caught once after reset so the offset never moves
	logic strap_r, strap_valid_r;
	always_ff @(posedge mclk) begin
		if (rst) begin
			strap_valid_r <= 1'b0;
			strap_r       <= 1'b0;
		end else if (!strap_valid_r) begin
			strap_valid_r <= 1'b1;
			strap_r       <= strap_s2_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frequency measurement over a fixed window
	logic [9:0]                 win_r;
	logic [pdm_pkg::EDGE_W-1:0] edges_r;
	logic [7:0]                 low_cnt_r;
	pdm_pkg::power_mode_t       mode_r, mode_nxt;
	wire win_end_w = (win_r == 10'(pdm_pkg::MEAS_WIN_CYC - 1));
	wire clk_off_w = (low_cnt_r == 8'(pdm_pkg::CLK_OFF_CYC));

	function automatic pdm_pkg::power_mode_t classify(input logic [7:0] n);
		if (n < pdm_pkg::LIM_STANDBY)
			return pdm_pkg::MODE_STANDBY;
		else if (n < pdm_pkg::LIM_LOW)
			return pdm_pkg::MODE_LOW_POWER;
		else if (n < pdm_pkg::LIM_NORMAL)
			return pdm_pkg::MODE_NORMAL;
		else if (n < pdm_pkg::LIM_HIGH)
			return pdm_pkg::MODE_HIGH_PERF;
		else
			return pdm_pkg::MODE_ULTRASONIC;
	endfunction

	always_comb begin
		mode_nxt = mode_r;
		if (clk_off_w)
			mode_nxt = pdm_pkg::MODE_OFF;
		else if (win_end_w)
			mode_nxt = classify(edges_r);
	end

	// Window counter and rising-edge tally
	always_ff @(posedge mclk) begin
		if (rst) begin
			win_r   <= '0;
			edges_r <= '0;
		end else begin
			win_r   <= win_end_w ? '0 : win_r + 10'h001;
			edges_r <= win_end_w ? '0 : edges_r + {7'h00, rise_w};
		end
	end

	// Clock-low time, held at the limit so clock-off stays asserted
	always_ff @(posedge mclk) begin
		if (rst || clk_s2_r)
			low_cnt_r <= '0;
		else if (!clk_off_w)
			low_cnt_r <= low_cnt_r + 8'h01;
	end

	// Mode register
	always_ff @(posedge mclk) begin
		if (rst)
			mode_r <= pdm_pkg::MODE_OFF;
		else
			mode_r <= mode_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Settling: idle tone after start or mode change until counter expires
	logic [31:0] settle_r;
	logic        mode_chg_r;
	wire active_w = (mode_r != pdm_pkg::MODE_OFF) && (mode_r != pdm_pkg::MODE_STANDBY);
	always_ff @(posedge mclk) begin
		if (rst) begin
			settle_r   <= '0;
			mode_chg_r <= 1'b0;
		end else begin
			mode_chg_r <= (mode_nxt != mode_r);
			if (!active_w || mode_chg_r)
				settle_r <= '0;
			else if (settle_r != 32'(SETTLE_CYC))
				settle_r <= settle_r + 32'h1;
		end
	end
	wire ready_w = (settle_r == 32'(SETTLE_CYC));

	////////////////////////////////////////////////////////////////////////
	// First-order modulator with a strap-set constant offset
	logic signed [pdm_pkg::SAMPLE_W+1:0] acc_r;
	logic [15:0] ofs_cnt_r;
	logic        idle_bit_r;
	wire  [15:0] ofs_per_w = strap_r ? 16'(pdm_pkg::OFS_PER_HIGH)
	                                 : 16'(pdm_pkg::OFS_PER_LOW);
	wire         ofs_tick_w = (ofs_cnt_r == ofs_per_w - 16'h0001);
	wire signed [pdm_pkg::SAMPLE_W+1:0] in_w =
		{{2{pressure[pdm_pkg::SAMPLE_W-1]}}, pressure} + (ofs_tick_w ? 18'sh00001 : 18'sh0);
	wire signed [pdm_pkg::SAMPLE_W+1:0] fb_w =
		acc_r[pdm_pkg::SAMPLE_W+1] ? -18'sh08000 : 18'sh08000;
	wire mod_bit_w = ~acc_r[pdm_pkg::SAMPLE_W+1];

	// Drive edge: strap low launches on fall, strap high on rise
	wire launch_w  = strap_r ? rise_w : fall_w;
	wire release_w = strap_r ? fall_w : rise_w;
	// A bit is only launched once the strap is known and the mode may drive
	wire take_w    = launch_w && active_w && strap_valid_r;
	wire drop_w    = release_w || !active_w;
	wire step_w    = take_w && ready_w;
	wire out_bit_w = ready_w ? mod_bit_w : ~idle_bit_r;

	logic data_r, oe_n_r, ready_r;

	// Idle pattern phase flips on every launched bit
	always_ff @(posedge mclk) begin
		if (rst)
			idle_bit_r <= 1'b0;
		else if (take_w)
			idle_bit_r <= ~idle_bit_r;
	end

	// Line enable: low from the launch edge until the release edge
	always_ff @(posedge mclk) begin
		if (rst)
			oe_n_r <= 1'b1;
		else if (take_w)
			oe_n_r <= 1'b0;
		else if (drop_w)
			oe_n_r <= 1'b1;
	end

	// Data bit held for the whole drive window
	always_ff @(posedge mclk) begin
		if (rst)
			data_r <= 1'b0;
		else if (take_w)
			data_r <= out_bit_w;
	end

	// Modulator only steps on launched bits, so its rate follows the clock
	always_ff @(posedge mclk) begin
		if (rst) begin
			acc_r     <= '0;
			ofs_cnt_r <= '0;
		end else if (step_w) begin
			acc_r     <= acc_r + in_w - fb_w;
			ofs_cnt_r <= ofs_tick_w ? '0 : ofs_cnt_r + 16'h0001;
		end
	end

	// Ready flag registered so the output comes from a flip-flop
	always_ff @(posedge mclk) begin
		if (rst)
			ready_r <= 1'b0;
		else
			ready_r <= ready_w;
	end

	assign link.data_o    = data_r;
	assign link.data_oe_n = oe_n_r;
	assign power_mode     = mode_r;
	assign audio_ready    = ready_r;

endmodule

/* pdm_pkg.sv */
// Package of constants shared by the microphone end and the receiver end
// Summary of operation
// - Strap low drives after fall, strap high after rise
// - Two devices interleave bits in alternate half-cycles
// - Shared clock sets one power mode for both
// - Idle pattern within 3 ms of clock and supply
// - Idle pattern alternates one and zero bits
// - Receiver waits 20 ms and 50 ms after start
// - Receiver waits 20 ms and 50 ms after mode switch
// - Offset level fixed by strap sampled at startup
// - Offset constant, independent of input amplitude
// - Rising pressure raises density of one bits
// - Standby mode keeps data line high impedance
package pdm_pkg;

	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_STANDBY,
		MODE_LOW_POWER,
		MODE_NORMAL,
		MODE_HIGH_PERF,
		MODE_ULTRASONIC
	} power_mode_t;

	localparam int SYS_CLK_HZ = 100_000_000;
	localparam int SYS_CLK_NS = 10;

	// Startup idle deadline and settling times in ms
	localparam int IDLE_START_MS  = 3;
	localparam int SETTLE_HALF_MS = 20;
	localparam int SETTLE_FINE_MS = 50;
	localparam int CYC_PER_MS     = 1_000_000 / SYS_CLK_NS;
	localparam int IDLE_START_CYC  = IDLE_START_MS * CYC_PER_MS;
	localparam int SETTLE_HALF_CYC = SETTLE_HALF_MS * CYC_PER_MS;
	localparam int SETTLE_FINE_CYC = SETTLE_FINE_MS * CYC_PER_MS;

	// Frequency measure window: 10 us, edge counts give clock in 100 kHz units
	localparam int MEAS_WIN_CYC = 1000;
	localparam int EDGE_W       = 8;
	// Mode thresholds in rising edges per window (100 kHz steps)
	localparam logic [7:0] LIM_STANDBY = 8'h04; // Below 0.4 MHz
	localparam logic [7:0] LIM_LOW     = 8'h0a; // Below 1.0 MHz
	localparam logic [7:0] LIM_NORMAL  = 8'h12; // Below 1.8 MHz
	localparam logic [7:0] LIM_HIGH    = 8'h27; // Below 3.9 MHz
	// Clock held low this long counts as clock-off, 2 us
	localparam int CLK_OFF_CYC = 200;

	// Offset dither periods for strap low and strap high
	localparam int OFS_PER_LOW  = 10000;
	localparam int OFS_PER_HIGH = 100;
	localparam int SAMPLE_W     = 16;

endpackage

/* pdm_link_if.sv */
// Interface carrying the shared clock and data line between both ends
`timescale 1ns/1ps
interface pdm_link_if;
	logic pdm_clk;     // Bit clock from the receiver
	logic data_o;      // Microphone data drive value
	logic data_oe_n;   // Microphone enable, low while driving
	logic data_line;   // Resolved line level
	assign data_line = !data_oe_n ? data_o : 1'b0;
	modport mic (input pdm_clk, output data_o, output data_oe_n);
	modport rcv (output pdm_clk, input data_line);
endinterface

/* pdm_rcv.sv */
// Receiver end: clock divider and two-slot data capture
`timescale 1ns/1ps
module pdm_rcv #(
	parameter int DIV_HALF = 32
) (
	// System
	input  wire logic mclk,
	input  wire logic rst,
	// Link
	pdm_link_if.rcv   link,
	// User side
	input  wire logic run,
	output logic      first_slot_channel,
	output logic      second_slot_channel,
	output logic      sample_valid,
	output logic      settled_half,
	output logic      settled_fine
);

	initial begin
		if (DIV_HALF < 2 || DIV_HALF > 255)
			$error("DIV_HALF out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Bit clock divider; one clock for both devices keeps one mode
	logic [7:0] div_r;
	logic       pclk_r;
	wire        half_w = (div_r == 8'(DIV_HALF - 1));
	always_ff @(posedge mclk) begin
		if (rst || !run) begin
			div_r  <= '0;
			pclk_r <= 1'b0;
		end else begin
			div_r  <= half_w ? '0 : div_r + 8'h01;
			if (half_w)
				pclk_r <= ~pclk_r;
		end
	end
	assign link.pdm_clk = pclk_r;

	////////////////////////////////////////////////////////////////////////
	// Line synchroniser; sample each slot just before the closing edge
	logic line_s1_r, line_s2_r;
	always_ff @(posedge mclk) begin
		line_s1_r <= link.data_line;
		line_s2_r <= line_s1_r;
	end
	wire late_w = (div_r == 8'(DIV_HALF - 2));

	logic first_r, second_r, valid_r;
	always_ff @(posedge mclk) begin
		if (rst) begin
			first_r  <= 1'b0;
			second_r <= 1'b0;
			valid_r  <= 1'b0;
		end else begin
			valid_r <= 1'b0;
			// Low half carries the strap-low device, high half the strap-high one
			if (run && late_w && !pclk_r)
				first_r <= line_s2_r;
			if (run && late_w && pclk_r) begin
				second_r <= line_s2_r;
				valid_r  <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Settling timers restart on start; a new divider needs a run toggle
	logic [31:0] wait_r;
	logic        half_r, fine_r;
	always_ff @(posedge mclk) begin
		if (rst || !run) begin
			wait_r <= '0;
			half_r <= 1'b0;
			fine_r <= 1'b0;
		end else begin
			if (!fine_r)
				wait_r <= wait_r + 32'h1;
			half_r <= half_r | (wait_r >= 32'(pdm_pkg::SETTLE_HALF_CYC));
			fine_r <= fine_r | (wait_r >= 32'(pdm_pkg::SETTLE_FINE_CYC));
		end
	end

	assign first_slot_channel  = first_r;
	assign second_slot_channel = second_r;
	assign sample_valid        = valid_r;
	assign settled_half        = half_r;
	assign settled_fine        = fine_r;

endmodule

/* pdm_link_monitor.sv */
// Concurrent checks on the shared clock and data line
`timescale 1ns/1ps
module pdm_link_monitor (
	// System
	input wire logic       mclk,
	input wire logic       rst,
	// Link
	input wire logic       pdm_clk,
	input wire logic       data_o,
	input wire logic       data_oe_n,
	// Microphone side
	input wire logic       side_strap_state,
	input wire logic [2:0] power_mode,
	input wire logic       audio_ready
);
	logic [7:0] low_cnt_r;
	logic       last_r;
	logic       have_r;
	wire        active;
	wire        quiet;
	// Mode decode for the checks
	assign active = power_mode >= 3'h2;
	assign quiet  = power_mode <= 3'h1;
	// Clock-low time, saturating so it never wraps back into range
	always_ff @(posedge mclk) begin
		if (rst || pdm_clk) low_cnt_r <= 8'h00;
		else if (low_cnt_r != 8'hff) low_cnt_r <= low_cnt_r + 8'h01;
	end
	// Last driven bit; cleared on a mode change since idle restarts there
	always_ff @(posedge mclk) begin
		if (rst || $changed(power_mode) || audio_ready) have_r <= 1'b0;
		else if ($rose(data_oe_n)) have_r <= 1'b1;
		if ($rose(data_oe_n)) last_r <= $past(data_o);
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	AST_LOW_DRIVES: assert property ($fell(pdm_clk) && !side_strap_state && active
		|-> ##4 !data_oe_n) else $error("low strap end did not drive");
	AST_HIGH_DRIVES: assert property ($rose(pdm_clk) && side_strap_state && active
		|-> ##4 !data_oe_n) else $error("high strap end did not drive");
	AST_LOW_RELEASES: assert property ($rose(pdm_clk) && !side_strap_state
		|-> ##4 data_oe_n) else $error("low strap end kept the line");
	AST_HIGH_RELEASES: assert property ($fell(pdm_clk) && side_strap_state
		|-> ##4 data_oe_n) else $error("high strap end kept the line");
	AST_DRIVE_STANDS: assert property ($fell(data_oe_n) |-> !data_oe_n [*8])
		else $error("drive window cut short");
	AST_BIT_STABLE: assert property (!data_oe_n && !$past(data_oe_n) |-> $stable(data_o))
		else $error("bit changed while driven");
	AST_STANDBY_HZ: assert property (quiet [*6] |-> data_oe_n)
		else $error("line driven in standby");
	AST_CLOCK_OFF: assert property (low_cnt_r >= 8'hf0 |-> power_mode == 3'h0)
		else $error("no clock-off state");
	AST_IDLE_TOGGLES: assert property ($rose(data_oe_n) && have_r && !audio_ready
		|-> $past(data_o) != last_r) else $error("idle bits repeat");
endmodule

/* test_pdm_mic_output_port.sv */
// Testbench joining the microphone and receiver ends over one link
`timescale 1ns/1ps
module test_pdm_mic_output_port;
	logic                                mclk;
	logic                                rst;
	logic                                strap;
	logic signed [pdm_pkg::SAMPLE_W-1:0] pressure;
	logic                                run;
	logic [2:0]                          power_mode;
	logic                                audio_ready;
	logic                                first_bit;
	logic                                second_bit;
	logic                                sample_valid;
	logic                                settled_half;
	logic                                settled_fine;
	logic                                b;
	logic                                prev;
	int                                  n_fail;
	int                                  compares;
	int                                  k;
	pdm_link_if link ();
	pdm_mic #(.SETTLE_CYC(1000)) u_pdm_mic (.mclk(mclk), .rst(rst), .link(link),
		.side_strap_state(strap), .pressure(pressure), .power_mode(power_mode),
		.audio_ready(audio_ready));
	pdm_rcv #(.DIV_HALF(32)) u_pdm_rcv (.mclk(mclk), .rst(rst), .link(link), .run(run),
		.first_slot_channel(first_bit), .second_slot_channel(second_bit),
		.sample_valid(sample_valid), .settled_half(settled_half), .settled_fine(settled_fine));
	pdm_link_monitor u_pdm_link_monitor (.mclk(mclk), .rst(rst), .pdm_clk(link.pdm_clk),
		.data_o(link.data_o), .data_oe_n(link.data_oe_n), .side_strap_state(strap),
		.power_mode(power_mode), .audio_ready(audio_ready));
	////////////////////////////////////////////////////////////////////////
	// Clock at 100 MHz
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic report_and_stop;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Bounded wait for the next received bit of one slot
	task automatic next_bit(input logic slot, output logic v);
		int i;
		i = 0;
		do begin
			@(posedge mclk);
			#1;
			i++;
		end while (sample_valid !== 1'b1 && i < 400);
		v = slot ? second_bit : first_bit;
		if (i >= 400) begin
			check(1'b0, "no sample");
			report_and_stop();
		end
	endtask
	task automatic wait_mode(input logic [2:0] m);
		int i;
		for (i = 0; i < 5000 && power_mode !== m; i++) begin
			@(posedge mclk);
			#1;
		end
		check(power_mode === m, "mode");
		if (power_mode !== m) report_and_stop();
	endtask
	// Reset with a strap level, then start the clock at the normal-mode rate
	task automatic start(input logic s);
		@(posedge mclk);
		rst <= 1'b1;
		strap <= s;
		run <= 1'b0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		check(link.data_oe_n === 1'b1 && power_mode === 3'h0, "reset");
		run <= 1'b1;
		wait_mode(pdm_pkg::MODE_NORMAL);
	endtask
	// Count ones of a slot over 64 bits, then compare against a bound
	task automatic density(input logic slot, input logic hi);
		int ones;
		ones = 0;
		repeat (64) begin
			next_bit(slot, b);
			ones += (b === 1'b1);
		end
		check(hi ? ones > 48 : ones < 16, "density");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		n_fail = 0;
		compares = 0;
		rst = 1'b1;
		strap = 1'b0;
		pressure = 16'sh0000;
		run = 1'b0;
		start(1'b0);
		next_bit(1'b0, b);
		next_bit(1'b0, prev);
		k = 0;
		while (audio_ready !== 1'b1 && k < 60) begin
			next_bit(1'b0, b);
			if (audio_ready !== 1'b1) check(b !== prev, "idle");
			prev = b;
			k++;
		end
		check(k > 3 && audio_ready === 1'b1, "idle span");
		if (audio_ready !== 1'b1) report_and_stop();
		check(settled_half === 1'b0 && settled_fine === 1'b0, "early settle");
		pressure <= 16'sh7000;
		density(1'b0, 1'b1);
		check(second_bit === 1'b0, "empty slot");
		pressure <= 16'sh9000;
		density(1'b0, 1'b0);
		start(1'b1);
		for (k = 0; k < 2000 && audio_ready !== 1'b1; k++) begin
			@(posedge mclk);
			#1;
		end
		check(audio_ready === 1'b1, "ready");
		if (audio_ready !== 1'b1) report_and_stop();
		pressure <= 16'sh7000;
		density(1'b1, 1'b1);
		check(first_bit === 1'b0, "empty slot");
		check(settled_half === 1'b0 && settled_fine === 1'b0, "early settle");
		run <= 1'b0;
		wait_mode(pdm_pkg::MODE_OFF);
		check(link.data_oe_n === 1'b1, "off drive");
		report_and_stop();
	end
endmodule
